// *** hw/positioning_status_outputs.sv ***
/*
 * positioning done / near flags and speed-limit-active flag of a servo drive.
 * assumes all inputs synchronous to sys_clk; ctrl_tick marks a control cycle.
 */
// Behaviour
// - done asserts when absolute position error is below the done width
// - done active means positioning complete, inactive means not complete
// - timing selector adds filtered-zero or raw-zero reference qualification
// - done drives its pin only when its pin assignment is set
// - near asserts when absolute position error is below the near width
// - near active means motor is near completion
// - near drives its pin only when its pin assignment is set
// - in torque control, limit flag active while speed reaches the limit
// - limit flag drives its pin only when its pin assignment is set
// - limit source picks internal setting or external commanded value
// - internal limit is min of setting and selected ceiling
`timescale 1ns/10ps
module positioning_status_outputs
    import pos_status_pkg::*;
#(
    parameter int EW = ERR_W,
    parameter int SW = SPD_W
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    input  wire logic                         ctrl_tick,
    input  wire logic                         restart,
    input  wire pos_status_pkg::restart_cfg_t cfg_in,
    input  wire pos_status_pkg::pin_assign_t  pin_assign,
    input  wire logic [31:0]                  done_width_setting,
    input  wire logic [31:0]                  near_width_setting,
    input  wire logic signed [EW-1:0]         ref_count,
    input  wire logic signed [EW-1:0]         motor_travel,
    input  wire logic                         filt_ref_zero,
    input  wire logic                         raw_ref_zero,
    input  wire logic                         torque_mode,
    input  wire logic [SW-1:0]                internal_speed_limit_setting,
    input  wire logic [SW-1:0]                external_speed_limit_value,
    input  wire logic [SW-1:0]                max_motor_speed,
    input  wire logic [SW-1:0]                overspeed_level,
    input  wire logic [SW-1:0]                motor_speed_abs,
    output logic                              positioning_done_out,
    output logic                              positioning_near_out,
    output logic                              speed_limit_active_out,
    output logic                              positioning_done_flag,
    output logic                              positioning_near_flag,
    output logic                              speed_limit_active_flag
);
    import pos_status_pkg::*;

    // ------------------------------------------------------------
    // restart-latched configuration
    // ------------------------------------------------------------
    restart_cfg_t cfg_r;
    logic         cfg_load_r;

    // selectors sampled on the cycle after reset release or on restart,
    // so a mid-run change is ignored until the drive restarts
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg_load_r <= 1'b1;
        end else begin
            cfg_load_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg_r <= '{TIMING_ERR_ONLY, SRC_INTERNAL, CEIL_MAX_SPEED};
        end else if (cfg_load_r || restart) begin
            cfg_r <= cfg_in;
        end
    end

    // ------------------------------------------------------------
    // position error magnitude
    // ------------------------------------------------------------
    logic signed [EW:0] err_full;
    logic [EW:0]        err_abs;
    logic [EW:0]        done_w;
    logic [EW:0]        near_w;

    function automatic logic [EW:0] clip_width(input logic [31:0] w,
                                               input logic [31:0] lo);
        logic [31:0] v;
        v = (w > DONE_WIDTH_MAX) ? DONE_WIDTH_MAX : ((w < lo) ? lo : w);
        return (EW + 1)'(v);
    endfunction

    // one extra bit so the difference never wraps
    always_comb begin
        err_full = (EW + 1)'(ref_count) - (EW + 1)'(motor_travel);
        err_abs  = err_full[EW] ? (EW + 1)'(-err_full) : err_full;
        done_w   = clip_width(done_width_setting, 32'h0);
        near_w   = clip_width(near_width_setting, NEAR_WIDTH_MIN);
    end

    // ------------------------------------------------------------
    // done qualification
    // ------------------------------------------------------------
    logic done_qual;

    always_comb begin
        unique case (cfg_r.done_timing_selector)
            TIMING_FILT_0: done_qual = filt_ref_zero;
            TIMING_RAW_0:  done_qual = raw_ref_zero;
            default:       done_qual = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // flags, refreshed once per control cycle
    // ------------------------------------------------------------
    logic limit_hit;

    speed_limit_check #(
        .W (SW)
    ) u_limit (
        .sys_clk                      (sys_clk),
        .reset_n                      (reset_n),
        .use_external                 (cfg_r.limit_source_selector),
        .ceil_overspeed               (cfg_r.limit_ceiling_selector),
        .internal_speed_limit_setting (internal_speed_limit_setting),
        .external_speed_limit_value   (external_speed_limit_value),
        .max_motor_speed              (max_motor_speed),
        .overspeed_level              (overspeed_level),
        .motor_speed_abs              (motor_speed_abs),
        .at_limit                     (limit_hit)
    );

    // widths take effect immediately, sampled at each control tick
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            positioning_done_flag <= 1'b0;
            positioning_near_flag <= 1'b0;
        end else if (ctrl_tick) begin
            positioning_done_flag <= (err_abs < done_w) && done_qual;
            positioning_near_flag <= (err_abs < near_w);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            speed_limit_active_flag <= 1'b0;
        end else if (ctrl_tick) begin
            speed_limit_active_flag <= torque_mode && limit_hit;
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    // unassigned signals leave their pin inactive (contact open)
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            positioning_done_out   <= 1'b0;
            positioning_near_out   <= 1'b0;
            speed_limit_active_out <= 1'b0;
        end else begin
            positioning_done_out   <= pin_assign.done_pin_assignment
                                      && positioning_done_flag;
            positioning_near_out   <= pin_assign.near_pin_assignment
                                      && positioning_near_flag;
            speed_limit_active_out <= pin_assign.limit_pin_assignment
                                      && speed_limit_active_flag;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    done_follows_err_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && (err_abs >= done_w) |=> !positioning_done_flag)
        else $error("done set with error at or above width");

    done_raw_qual_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && cfg_r.done_timing_selector == TIMING_RAW_0 && !raw_ref_zero
        |=> !positioning_done_flag)
        else $error("done set while raw reference nonzero");

    near_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && (err_abs < near_w) |=> positioning_near_flag)
        else $error("near missing with small error");

    done_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        positioning_done_out |-> $past(pin_assign.done_pin_assignment))
        else $error("done pin active while unassigned");

    near_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(pin_assign.near_pin_assignment && positioning_near_flag)
        == positioning_near_out)
        else $error("near pin mismatch");

    limit_torque_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && !torque_mode |=> !speed_limit_active_flag)
        else $error("limit flag outside torque control");

    limit_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !pin_assign.limit_pin_assignment |=> !speed_limit_active_out)
        else $error("limit pin active while unassigned");

    hold_no_tick_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !ctrl_tick |=> $stable(positioning_near_flag) && $stable(positioning_done_flag))
        else $error("flag changed without control tick");

    cfg_stable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !restart && !cfg_load_r |=> $stable(cfg_r))
        else $error("selector changed without restart");

    // the set side of done, so a stuck-low flag is caught as well
    done_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && (err_abs < done_w) && done_qual |=> positioning_done_flag)
        else $error("done missing with small error");

    near_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && (err_abs >= near_w) |=> !positioning_near_flag)
        else $error("near set with error at or above width");

    limit_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_tick && torque_mode && limit_hit |=> speed_limit_active_flag)
        else $error("limit flag missing at limit speed");

    // no disable here: this one must watch the reset itself
    reset_quiet_a: assert property (@(posedge sys_clk)
        !reset_n |=> !positioning_done_flag && !positioning_near_flag
        && !speed_limit_active_flag && !positioning_done_out
        && !positioning_near_out && !speed_limit_active_out)
        else $error("status output active after reset");

endmodule

// *** hw/pos_status_pkg.sv ***
/*
 * shared constants and carrier types for the positioning status outputs.
 * assumes a single 200 MHz system clock and synchronous inputs.
 */
package pos_status_pkg;

    localparam int          ERR_W           = 32;
    localparam int          SPD_W           = 16;
    localparam logic [31:0] DONE_WIDTH_MAX  = 32'h4000_0000;
    localparam logic [31:0] DONE_WIDTH_RST  = 32'h0000_0007;
    localparam logic [31:0] NEAR_WIDTH_MIN  = 32'h0000_0001;
    localparam logic [31:0] NEAR_WIDTH_RST  = 32'h4000_0000;
    localparam logic [1:0]  TIMING_ERR_ONLY = 2'h0;
    localparam logic [1:0]  TIMING_FILT_0   = 2'h1;
    localparam logic [1:0]  TIMING_RAW_0    = 2'h2;
    localparam logic        SRC_INTERNAL    = 1'h0;
    localparam logic        SRC_EXTERNAL    = 1'h1;
    localparam logic        CEIL_MAX_SPEED  = 1'h0;
    localparam logic        CEIL_OVERSPEED  = 1'h1;
    localparam logic [15:0] INT_LIMIT_RST   = 16'h2710;

    // selectors that only change at reset, on reset release or at restart
    typedef struct packed {
        logic [1:0] done_timing_selector;
        logic       limit_source_selector;
        logic       limit_ceiling_selector;
    } restart_cfg_t;

    // pin routing enables
    typedef struct packed {
        logic done_pin_assignment;
        logic near_pin_assignment;
        logic limit_pin_assignment;
    } pin_assign_t;

endpackage

// *** hw/speed_limit_check.sv ***
/*
 * speed limit selection and reached detection.
 * assumes speeds share one unsigned unit and are synchronous to sys_clk.
 */
`timescale 1ns/10ps
module speed_limit_check
    import pos_status_pkg::*;
#(
    parameter int W = SPD_W
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         use_external,
    input  wire logic         ceil_overspeed,
    input  wire logic [W-1:0] internal_speed_limit_setting,
    input  wire logic [W-1:0] external_speed_limit_value,
    input  wire logic [W-1:0] max_motor_speed,
    input  wire logic [W-1:0] overspeed_level,
    input  wire logic [W-1:0] motor_speed_abs,
    output logic              at_limit
);

    logic [W-1:0] ceiling;
    logic [W-1:0] limit_eff;

    // internal limit is clipped by the chosen ceiling
    always_comb begin
        ceiling = ceil_overspeed ? overspeed_level : max_motor_speed;
        if (use_external) begin
            limit_eff = external_speed_limit_value;
        end else if (internal_speed_limit_setting < ceiling) begin
            limit_eff = internal_speed_limit_setting;
        end else begin
            limit_eff = ceiling;
        end
    end

    // registered on every sys_clk edge; the flag samples it once per control tick
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            at_limit <= 1'b0;
        end else begin
            at_limit <= (motor_speed_abs >= limit_eff);
        end
    end

endmodule

// *** verification/host_ctrl.sv ***
/*
 * model of the host motion controller on the far side of the status pins.
 * assumes the same sys_clk as the drive; pins are active high.
 */
`timescale 1ns/10ps
module host_ctrl (
    input  wire logic               sys_clk,
    input  wire logic [31:0]        target,
    input  wire logic               done_pin,
    input  wire logic               near_pin,
    output logic signed [31:0]      ref_count,
    output logic                    prep
);
    // issued reference count, registered like a real host output
    always_ff @(posedge sys_clk) begin
        ref_count <= target;
    end

    // near before done lets the host set up its next move early
    always_ff @(posedge sys_clk) begin
        prep <= near_pin & ~done_pin;
    end
endmodule

// *** verification/positioning_status_outputs_tb.sv ***
/*
 * self-checking bench for the positioning status outputs.
 * assumes flags one edge after a tick and pins one edge after flags.
 */
`timescale 1ns/10ps
module positioning_status_outputs_tb;
    import pos_status_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic               sys_clk = 0, reset_n = 0, ctrl_tick = 0, restart = 0;
    logic               filt_ref_zero = 0, raw_ref_zero = 0, torque_mode = 0;
    restart_cfg_t       cfg_in = '0;
    pin_assign_t        pin_assign = 3'h7;
    logic [31:0]        done_width_setting = DONE_WIDTH_RST, target = '0;
    logic [31:0]        near_width_setting = NEAR_WIDTH_RST;
    logic signed [31:0] ref_count, motor_travel = '0;
    logic [15:0]        internal_speed_limit_setting = INT_LIMIT_RST;
    logic [15:0]        external_speed_limit_value = '0, motor_speed_abs = '0;
    logic [15:0]        max_motor_speed = 16'hffff, overspeed_level = 16'hffff;
    logic               positioning_done_out, positioning_near_out, speed_limit_active_out;
    logic               positioning_done_flag, positioning_near_flag, speed_limit_active_flag;
    logic               prep;
    int                 failures = 0, checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    host_ctrl host (.sys_clk, .target, .done_pin(positioning_done_out),
        .near_pin(positioning_near_out), .ref_count, .prep);

    positioning_status_outputs DUT (.sys_clk, .reset_n, .ctrl_tick, .restart, .cfg_in,
        .pin_assign, .done_width_setting, .near_width_setting, .ref_count, .motor_travel,
        .filt_ref_zero, .raw_ref_zero, .torque_mode, .internal_speed_limit_setting,
        .external_speed_limit_value, .max_motor_speed, .overspeed_level, .motor_speed_abs,
        .positioning_done_out, .positioning_near_out, .speed_limit_active_out,
        .positioning_done_flag, .positioning_near_flag, .speed_limit_active_flag);

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t flag or pin wrong", $time);
        end
    endtask

    // inputs always move 1 ns after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    // one control-cycle strobe, then wait until the pins have followed
    task automatic run(input logic signed [31:0] e, input logic d, n, l);
        target = e;
        step(1);
        ctrl_tick = 1;
        step(1);
        ctrl_tick = 0;
        step(2);
        chk(positioning_done_flag, d);
        chk(positioning_near_flag, n);
        chk(speed_limit_active_flag, l);
        chk(positioning_done_out, d & pin_assign.done_pin_assignment);
        chk(positioning_near_out, n & pin_assign.near_pin_assignment);
        chk(speed_limit_active_out, l & pin_assign.limit_pin_assignment);
        chk(prep, (n & pin_assign.near_pin_assignment)
            & ~(d & pin_assign.done_pin_assignment));
    endtask

    task automatic rs(input restart_cfg_t c);
        cfg_in = c;
        restart = 1;
        step(1);
        restart = 0;
    endtask

    task automatic wrap_up;
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        step(2);
        chk(positioning_done_out | positioning_near_flag, 1'h0);
        reset_n = 1;
        run(32'sh6, 1'h1, 1'h1, 1'h0);
        run(32'sh7, 1'h0, 1'h1, 1'h0);
        run(-32'sh6, 1'h1, 1'h1, 1'h0);
        // error is reference minus travel, so move the motor side too
        motor_travel = 32'sh28;
        run(32'sh2e, 1'h1, 1'h1, 1'h0);
        run(32'sh21, 1'h0, 1'h1, 1'h0);
        motor_travel = '0;
        near_width_setting = 32'h0000_0064;
        run(32'sh63, 1'h0, 1'h1, 1'h0);
        run(32'sh64, 1'h0, 1'h0, 1'h0);
        target = '0;
        step(3);
        chk(positioning_near_flag, 1'h0);
        pin_assign = '0;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        pin_assign = 3'h7;
        cfg_in = restart_cfg_t'{TIMING_FILT_0, SRC_INTERNAL, CEIL_MAX_SPEED};
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        rs(cfg_in);
        run(32'sh0, 1'h0, 1'h1, 1'h0);
        filt_ref_zero = 1;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        rs(restart_cfg_t'{TIMING_RAW_0, SRC_INTERNAL, CEIL_MAX_SPEED});
        run(32'sh0, 1'h0, 1'h1, 1'h0);
        raw_ref_zero = 1;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        rs('0);
        torque_mode = 1;
        internal_speed_limit_setting = 16'h03e8;
        max_motor_speed = 16'h0320;
        motor_speed_abs = 16'h0320;
        run(32'sh0, 1'h1, 1'h1, 1'h1);
        motor_speed_abs = 16'h031f;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        rs(restart_cfg_t'{TIMING_ERR_ONLY, SRC_INTERNAL, CEIL_OVERSPEED});
        overspeed_level = 16'h07d0;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        motor_speed_abs = 16'h03e8;
        run(32'sh0, 1'h1, 1'h1, 1'h1);
        rs(restart_cfg_t'{TIMING_ERR_ONLY, SRC_EXTERNAL, CEIL_MAX_SPEED});
        external_speed_limit_value = 16'h012c;
        motor_speed_abs = 16'h012b;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        motor_speed_abs = 16'h012c;
        run(32'sh0, 1'h1, 1'h1, 1'h1);
        torque_mode = 0;
        run(32'sh0, 1'h1, 1'h1, 1'h0);
        done_width_setting = 32'hffff_ffff;
        run(32'sh3fff_ffff, 1'h1, 1'h0, 1'h0);
        reset_n = 0;
        step(1);
        chk(positioning_done_flag | positioning_near_out, 1'h0);
        // second release: selectors load from cfg_in with no restart pulse
        step(1);
        cfg_in = restart_cfg_t'{TIMING_FILT_0, SRC_INTERNAL, CEIL_MAX_SPEED};
        filt_ref_zero = 0;
        reset_n = 1;
        run(32'sh0, 1'h0, 1'h1, 1'h0);
        wrap_up();
    end
endmodule
